// file: dv/ahs_host_model.sv
/*
 * Behavioural host driving the multiplexed bus of the history stack.
 * Assumes the bench calls its tasks at a falling edge of clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module ahs_host_model (
    // Device clock.
    input wire logic clock_i,
    // Bus pins toward the device.
    output var logic ale_o,
    output var logic cs_n_o,
    output var logic rd_n_o,
    output var logic wr_n_o,
    output var logic [7:0] ad_o
);
    // ------------------------------------------------------------------
    // Idle levels at time zero.
    // ------------------------------------------------------------------
    initial begin
        ale_o = 1'b0;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        ad_o = 8'h00;
    end

    // ------------------------------------------------------------------
    // Bus cycles; each level is held long enough for the synchronisers.
    // ------------------------------------------------------------------
    // Waits a number of falling edges.
    task automatic hold(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Address latch; lines are scrambled once their hold time has run out.
    task automatic latch(input logic [7:0] addr, input logic sel);
        ale_o = 1'b1;
        cs_n_o = ~sel;
        ad_o = addr;
        hold(4);
        ale_o = 1'b0;
        hold(4);
        ad_o = ~addr;
    endtask

    // Read pulse; the device answers while the strobe is low.
    task automatic rd();
        rd_n_o = 1'b0;
        hold(8);
        rd_n_o = 1'b1;
        hold(6);
    endtask

    // Write pulse; data holds past the rising strobe, then is scrambled.
    task automatic wr(input logic [7:0] data);
        ad_o = data;
        wr_n_o = 1'b0;
        hold(4);
        wr_n_o = 1'b1;
        hold(4);
        ad_o = ~data;
        hold(4);
    endtask

    // Control register access that moves the bank select bit.
    task automatic set_bank(input logic b);
        latch(8'h0A, 1'b1);
        wr({3'h0, b, 4'h0});
    endtask
endmodule // ahs_host_model

`default_nettype wire

// file: dv/ahs_top_tb_top.sv
/*
 * Self-checking bench for the address history stack.
 * Assumes the host model drives the pins and the design files hold the
 * assertions.
 */
`timescale 1ns/1ps
`default_nettype none

module ahs_top_tb_top
    import ahs_pkg::*;
;
    logic clock_i;
    logic nrst_i;
    logic ale, cs_n, rd_n, wr_n, ad_oe, bank, oe_q;
    logic [7:0] ad_host, ad_dev, a, b, c;
    logic [7:0] v[3];
    logic [7:0] exp_q[$];
    int errors = 0;
    int cmp_count = 0;
    int seed;

    // ------------------------------------------------------------------
    // Clock, host and device.
    // ------------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    ahs_host_model host (.clock_i(clock_i), .ale_o(ale), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .ad_o(ad_host));

    ahs_top #(.WIDTH(8)) DUT (.clock_i(clock_i), .nrst_i(nrst_i),
        .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .ad_i(ad_host), .ad_o(ad_dev), .ad_oe_o(ad_oe),
        .bank_select_bit_o(bank));

    // ------------------------------------------------------------------
    // Comparison, verdict and read helper.
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Notes the expected byte, then latches and reads the offset.
    task automatic expect_read(input logic [7:0] addr, input logic [7:0] e);
        exp_q.push_back(e);
        host.latch(addr, 1'b1);
        host.rd();
    endtask

    // Each new drive of the lines takes the oldest note; with no note
    // waiting the device should not have driven at all.
    initial oe_q = 1'b0;
    always @(negedge clock_i) begin
        if (ad_oe === 1'b1 && oe_q !== 1'b1) begin
            if (exp_q.size() == 0) begin
                check({7'h00, ad_oe}, 8'h00);
            end else begin
                check(ad_dev, exp_q.pop_front());
            end
        end
        oe_q = ad_oe;
    end

    // Cuts a hang short; the full run needs well under a tenth of this.
    initial begin
        #100000;
        errors++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(32'hC470);
        nrst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        nrst_i = 1'b1;
        @(negedge clock_i);
        check({6'h00, ad_oe, bank}, 8'h00);
        // Bank zero: the lost address slot at 4Eh stays undriven.
        host.set_bank(1'b0);
        check({7'h00, bank}, 8'h00);
        expect_read(8'h0A, 8'h00);
        host.latch(8'h4E, 1'b1);
        host.rd();
        host.set_bank(1'b1);
        check({7'h00, bank}, 8'h01);
        expect_read(8'h0A, 8'h10);
        // Lost address recovered after the 0Ah and 4Eh latches.
        repeat (4) begin
            a = 8'($urandom);
            host.latch(a, 1'b1);
            host.set_bank(1'b1);
            expect_read(8'h4E, a);
        end
        // Three addresses, then 4Fh returns the oldest of four.
        repeat (4) begin
            foreach (v[j]) begin
                v[j] = 8'($urandom);
                host.latch(v[j], 1'b1);
            end
            expect_read(8'h4F, v[0]);
        end
        // A deselected latch must not push.
        a = 8'($urandom);
        b = 8'($urandom);
        c = 8'($urandom);
        host.latch(a, 1'b1);
        host.latch(b, 1'b0);
        host.latch(c, 1'b1);
        expect_read(8'h4E, a);
        // A write to the stack slot leaves the history alone.
        host.latch(a, 1'b1);
        host.latch(b, 1'b1);
        host.latch(8'h4E, 1'b1);
        host.wr(~b);
        expect_read(8'h4E, b);
        // Unmapped offset is never driven.
        host.latch(8'h33, 1'b1);
        host.rd();
        check(8'(exp_q.size()), 8'h00);
        complete_run();
    end
endmodule // ahs_top_tb_top

`default_nettype wire

// file: rtl/ahs_cfg.svh
/*
 * Constants of the address history stack: offsets, field positions,
 * reset values and widths.
 * Assumes it is included by bare name from design files of this block.
 */
`ifndef AHS_CFG_SVH
`define AHS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define AHS_CTRL_A_OFS 8'h0A
`define AHS_LOST_SLOT_OFS 8'h4E
`define AHS_OLDER_SLOT_OFS 8'h4F

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define AHS_BANK_BIT_POS 4
`define AHS_BANK_RST 1'b0
`define AHS_ENTRY_RST 8'h00
`define AHS_DATA_W 8
`define AHS_DEPTH 4
`define AHS_LOST_IDX 2
`define AHS_OLDER_IDX 3

`endif

// file: rtl/ahs_pkg.sv
/*
 * Types shared by the address history stack design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ahs_pkg;

    // Bus access state; Gray codes along idle, latched, read.
    typedef enum logic [1:0] {
        AHS_ST_IDLE = 2'b00,
        AHS_ST_LATCHED = 2'b01,
        AHS_ST_READ = 2'b11,
        AHS_ST_WRITE = 2'b10
    } ahs_state_t;

endpackage
`default_nettype wire

// file: rtl/ahs_stack.sv
/*
 * Shift stack of latched register addresses; entry 0 is the newest.
 * Assumes push_i is a single-cycle pulse in the clock_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ahs_cfg.svh"

module ahs_stack #(
    parameter int DEPTH = `AHS_DEPTH,
    parameter int WIDTH = `AHS_DATA_W
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic nrst_i,
    // Push port.
    input wire logic push_i,
    input wire logic [WIDTH-1:0] data_i,
    // Stored entries, newest in index 0.
    output logic [DEPTH-1:0][WIDTH-1:0] entries_o
);

    logic [DEPTH-1:0][WIDTH-1:0] entry_r;
    logic [DEPTH-1:0][WIDTH-1:0] entry_nxt;

    // A push moves every entry one older and drops the oldest one.
    always_comb begin
        entry_nxt = entry_r;
        if (push_i) begin
            entry_nxt[0] = data_i; // RULE_03
            for (int i = 1; i < DEPTH; i++) begin
                entry_nxt[i] = entry_r[i-1]; // RULE_04
            end
        end
    end

    // Registers only.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            entry_r <= '0;
        end else begin
            entry_r <= entry_nxt;
        end
    end

    assign entries_o = entry_r;

endmodule // ahs_stack
`default_nettype wire

// file: rtl/ahs_top.sv
/*
 * Address history stack behind the multiplexed byte-wide host bus.
 * Assumes the host drives ALE, chip select, read and write strobes
 * asynchronously; all pins are synchronised to clock_i at 100 MHz.
 */
// Functional notes
// RULE_01: Stack readable at 4Eh and 4Fh, bank one.
// RULE_02: Address captured on falling address latch strobe.
// RULE_03: Each capture pushes; new address becomes current.
// RULE_04: Four entries deep; oldest entry dropped.
// RULE_05: Host latches 0Ah to set bank select.
// RULE_06: After 0Ah, 4Eh, read gives lost address.
// RULE_07: Host sets bank select before extended access.
// RULE_08: Stack slots are read-only; writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "ahs_cfg.svh"

module ahs_top
    import ahs_pkg::*;
#(
    parameter int WIDTH = `AHS_DATA_W
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic nrst_i,
    // Host bus strobes, asynchronous pins.
    input wire logic ale_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    // Multiplexed address/data lines.
    input wire logic [WIDTH-1:0] ad_i,
    output logic [WIDTH-1:0] ad_o,
    output logic ad_oe_o,
    // Extended bank selection state.
    output logic bank_select_bit_o
);

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Decodes an offset that falls on one of the two stack slots.
    function automatic logic is_stack_ofs(input logic [WIDTH-1:0] a);
        return (a == `AHS_LOST_SLOT_OFS) || (a == `AHS_OLDER_SLOT_OFS);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic ale_q1, ale_q2, ale_d_r;
    logic cs_n_q1, cs_n_q2;
    logic rd_n_q1, rd_n_q2, rd_n_d_r;
    logic wr_n_q1, wr_n_q2, wr_n_d_r;
    logic [WIDTH-1:0] ad_q1, ad_q2;

    // Two stages per pin, a third on ALE, read and write for edges; logic never reads the first stage.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ale_q1 <= 1'b0;
            ale_q2 <= 1'b0;
            ale_d_r <= 1'b0;
            cs_n_q1 <= 1'b1;
            cs_n_q2 <= 1'b1;
            rd_n_q1 <= 1'b1;
            rd_n_q2 <= 1'b1;
            rd_n_d_r <= 1'b1;
            wr_n_q1 <= 1'b1;
            wr_n_q2 <= 1'b1;
            wr_n_d_r <= 1'b1;
            ad_q1 <= '0;
            ad_q2 <= '0;
        end else begin
            ale_q1 <= ale_i;
            ale_q2 <= ale_q1;
            ale_d_r <= ale_q2;
            cs_n_q1 <= cs_n_i;
            cs_n_q2 <= cs_n_q1;
            rd_n_q1 <= rd_n_i;
            rd_n_q2 <= rd_n_q1;
            rd_n_d_r <= rd_n_q2;
            wr_n_q1 <= wr_n_i;
            wr_n_q2 <= wr_n_q1;
            wr_n_d_r <= wr_n_q2;
            ad_q1 <= ad_i;
            ad_q2 <= ad_q1;
        end
    end

    // ------------------------------------------------------------------
    // Strobe edges.
    // ------------------------------------------------------------------
    // The address lines share the strobe's delay, so the byte sampled
    // with the edge is the one present when the strobe fell.
    logic push_w, rd_fall_w, rd_rise_w, wr_fall_w, wr_rise_w;
    assign push_w = ale_d_r && !ale_q2 && !cs_n_q2; // RULE_02
    assign rd_fall_w = rd_n_d_r && !rd_n_q2 && !cs_n_q2;
    assign rd_rise_w = !rd_n_d_r && rd_n_q2;
    assign wr_fall_w = wr_n_d_r && !wr_n_q2 && !cs_n_q2;
    assign wr_rise_w = !wr_n_d_r && wr_n_q2;

    // ------------------------------------------------------------------
    // History stack.
    // ------------------------------------------------------------------
    logic [`AHS_DEPTH-1:0][WIDTH-1:0] stack_w;

    ahs_stack #(
        .DEPTH(`AHS_DEPTH),
        .WIDTH(WIDTH)
    ) u_stack (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .push_i(push_w), // RULE_03
        .data_i(ad_q2),
        .entries_o(stack_w)
    );

    // ------------------------------------------------------------------
    // Bus access sequencing and registers.
    // ------------------------------------------------------------------
    ahs_state_t state_r, state_nxt;
    logic [WIDTH-1:0] addr_r, addr_nxt;
    logic bank_r, bank_nxt;
    logic [WIDTH-1:0] ad_o_r, ad_o_nxt;
    logic ad_oe_r, ad_oe_nxt;
    logic readable_w;
    logic [WIDTH-1:0] rdata_w;

    // Read mux; unmapped offsets leave the lines undriven.
    always_comb begin
        readable_w = 1'b0;
        rdata_w = '0;
        if (addr_r == `AHS_CTRL_A_OFS) begin
            readable_w = 1'b1;
            rdata_w[`AHS_BANK_BIT_POS] = bank_r;
        end else if (bank_r && is_stack_ofs(addr_r)) begin
            readable_w = 1'b1; // RULE_01
            rdata_w = (addr_r == `AHS_LOST_SLOT_OFS) ?
                stack_w[`AHS_LOST_IDX] : stack_w[`AHS_OLDER_IDX]; // RULE_06
        end
    end

    // A new address latch always wins over a pending access.
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        bank_nxt = bank_r;
        if (push_w) begin
            addr_nxt = ad_q2;
            state_nxt = AHS_ST_LATCHED;
        end else begin
            case (state_r)
                AHS_ST_IDLE: begin
                    state_nxt = AHS_ST_IDLE;
                end
                AHS_ST_LATCHED: begin
                    if (rd_fall_w) begin
                        state_nxt = AHS_ST_READ;
                    end else if (wr_fall_w) begin
                        state_nxt = AHS_ST_WRITE;
                    end
                end
                AHS_ST_READ: begin
                    if (rd_rise_w) begin
                        state_nxt = AHS_ST_LATCHED;
                    end
                end
                AHS_ST_WRITE: begin
                    if (wr_rise_w) begin
                        state_nxt = AHS_ST_LATCHED;
                        // Only the control register takes data; a write
                        // to a stack slot changes nothing stored.
                        if (addr_r == `AHS_CTRL_A_OFS) begin // RULE_08
                            bank_nxt = ad_q2[`AHS_BANK_BIT_POS];
                        end
                    end
                end
                default: begin
                    state_nxt = AHS_ST_IDLE;
                end
            endcase
        end
        ad_oe_nxt = (state_nxt == AHS_ST_READ) && readable_w;
        ad_o_nxt = ad_oe_nxt ? rdata_w : '0;
    end

    // Registers only.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= AHS_ST_IDLE;
            addr_r <= `AHS_ENTRY_RST;
            bank_r <= `AHS_BANK_RST;
            ad_o_r <= '0;
            ad_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            bank_r <= bank_nxt;
            ad_o_r <= ad_o_nxt;
            ad_oe_r <= ad_oe_nxt;
        end
    end

    assign ad_o = ad_o_r;
    assign ad_oe_o = ad_oe_r;
    assign bank_select_bit_o = bank_r;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_strobe_fall;
        (ale_q2 && !cs_n_q2) ##1 (!ale_q2 && !cs_n_q2);
    endsequence

    a_latch_edge: assert property ( // RULE_02
        s_strobe_fall |-> push_w ##1 (stack_w[0] == $past(ad_q2)))
        else $error("Falling strobe did not capture the address.");

    a_push_shift: assert property ( // RULE_03
        push_w |=> (stack_w[1] == $past(stack_w[0]))
            && (stack_w[2] == $past(stack_w[1])))
        else $error("Push did not age the stack entries.");

    a_depth_four: assert property ( // RULE_04
        push_w |=> stack_w[3] == $past(stack_w[2]))
        else $error("Third older entry not kept after a push.");

    a_stack_hold: assert property ( // RULE_08
        (state_r == AHS_ST_WRITE && wr_rise_w && !push_w) |=>
            $stable(stack_w) [*2])
        else $error("A write disturbed the stored history.");

    // The slot latch that directly follows a control register latch.
    sequence s_recovery_latches;
        push_w && ad_q2 == `AHS_LOST_SLOT_OFS
            && stack_w[0] == `AHS_CTRL_A_OFS;
    endsequence

    // The address held before the control latch must land in entry two.
    a_lost_recover: assert property ( // RULE_06
        s_recovery_latches |=>
            stack_w[1] == `AHS_CTRL_A_OFS
            && stack_w[0] == `AHS_LOST_SLOT_OFS
            && stack_w[`AHS_LOST_IDX] == $past(stack_w[1]))
        else $error("Stack order after recovery latches is wrong.");

    a_slot_read: assert property ( // RULE_01
        (state_nxt == AHS_ST_READ && bank_r && !push_w
            && addr_r == `AHS_LOST_SLOT_OFS) |=>
            ad_oe_r && ad_o_r == $past(stack_w[`AHS_LOST_IDX]))
        else $error("Lost address slot read returned wrong data.");

    a_bank_gate: assert property ( // RULE_01
        (ad_oe_r && is_stack_ofs(addr_r)) |-> $past(bank_r))
        else $error("Stack slot driven with bank select clear.");

    // The lines may only be driven while the seen read strobe is low.
    a_drive_read: assert property ( // RULE_01
        ad_oe_r |-> (state_r == AHS_ST_READ) && !rd_n_d_r)
        else $error("Bus driven outside a read access.");

endmodule // ahs_top
`default_nettype wire
